/* File: logic/bdma_top.sv */
// bdma_top: banked data memory, pointers, bank select, alu holder, pc low.
// assumes the core drives one access per cycle on sys_clk; apb for debug.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module bdma_top #(
    parameter int PC_W = bdma_pkg::PC_W
) (
    input  wire logic            sys_clk,
    input  wire logic            reset,
    input  wire logic            wdtPowerDownReset,
    // core access port
    input  wire logic [7:0]      coreAddr,
    input  wire logic            coreRead,
    input  wire logic            coreWrite,
    input  wire logic            coreBitOp,
    input  wire logic            coreBitSet,
    input  wire logic [2:0]      coreBitSel,
    input  wire logic [7:0]      coreWdata,
    output logic      [7:0]      coreRdata,
    input  wire logic            aluLoad,
    input  wire logic [7:0]      aluResult,
    output logic      [7:0]      aluHolder,
    input  wire logic            statusLoad,
    input  wire logic [7:0]      statusIn,
    output logic      [7:0]      statusOut,
    input  wire logic            pcAdvance,
    output logic      [PC_W-1:0] programCounter,
    output logic                 dummyCycle,
    output logic      [7:0]      eepromControl,
    // apb
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr
);
    typedef struct packed {
        logic [7:0]      pointerZero;
        logic [7:0]      pointerOne;
        logic [7:0]      bankSelect;
        logic [7:0]      aluHold;
        logic [7:0]      status;
        logic [7:0]      eec;
        logic [PC_W-1:0] pc;
        logic            dummy;
        logic [7:0]      rdata;
        logic [31:0]     prdata;
    } bdma_state_t;

    bdma_state_t state;
    bdma_state_t next_state;

    logic        apbRd;
    logic        apbWr;
    logic        apbHit;
    logic        acc;
    logic        wr;
    logic [8:0]  effAddr;
    logic [7:0]  wdata;
    logic [7:0]  wmask;
    logic [7:0]  ramRdata;
    logic        ramWe;
    logic [7:0]  readVal;
    logic        apbBank1;

    bdma_apb_slave u_apb (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .pready   (pready),
        .rdStrobe (apbRd),
        .wrStrobe (apbWr)
    );

    // apb data window: word index gives the byte address
    assign apbHit   = (paddr[11:10] == 2'b00) || (paddr[11:10] == 2'b01);
    assign apbBank1 = paddr[11:10] == 2'b01;
    assign pslverr  = 1'b0;

    // address resolution
    always_comb
    begin
        acc     = coreRead || coreWrite || coreBitOp;
        wr      = coreWrite || coreBitOp;
        effAddr = {1'b0, coreAddr};
        wdata   = coreWdata;
        wmask   = 8'hff;
        if (!acc && (apbRd || apbWr) && apbHit)
        begin
            effAddr = {apbBank1, paddr[9:2]};
            wr      = apbWr;
            wdata   = pwdata[7:0];
        end
        else if (coreAddr == bdma_pkg::SFR_PORT_ZERO)
        begin
            effAddr = {1'b0, state.pointerZero};
        end
        else if (coreAddr == bdma_pkg::SFR_PORT_ONE)
        begin
            effAddr = {state.bankSelect[bdma_pkg::BANK_BIT], state.pointerOne};
        end
        if (coreBitOp && acc)
        begin
            wmask = 8'h01 << coreBitSel;
            wdata = coreBitSet ? 8'hff : bdma_pkg::ZERO_BYTE;
        end
    end

    assign ramWe = wr && !effAddr[8] && effAddr[7];

    bdma_gp_ram #(
        .DEPTH (128),
        .AW    (7)
    ) u_ram (
        .sys_clk (sys_clk),
        .addr    (effAddr[6:0]),
        .we      (ramWe),
        .wmask   (wmask),
        .wdata   (wdata),
        .rdata   (ramRdata)
    );

    // read mux, 8-bit words from 00h up
    always_comb
    begin
        readVal = bdma_pkg::ZERO_BYTE;
        if (effAddr[8])
        begin
            if (effAddr[7:0] == bdma_pkg::EEC_ADDR)
            begin
                readVal = state.eec;
            end
        end
        else if (effAddr[7])
        begin
            readVal = ramRdata;
        end
        else
        begin
            case (effAddr[7:0])
                bdma_pkg::SFR_PTR_ZERO:    readVal = state.pointerZero;
                bdma_pkg::SFR_PTR_ONE:     readVal = state.pointerOne;
                bdma_pkg::SFR_BANK_SELECT: readVal = state.bankSelect & 8'h01;
                bdma_pkg::SFR_ALU_HOLD:    readVal = state.aluHold;
                bdma_pkg::SFR_PC_LOW:      readVal = state.pc[7:0];
                bdma_pkg::SFR_STATUS:      readVal = state.status;
                default:                   readVal = bdma_pkg::ZERO_BYTE;
            endcase
        end
    end

    always_comb
    begin
        next_state       = state;
        next_state.dummy = 1'b0;
        if (pcAdvance && !state.dummy)
        begin
            next_state.pc = state.pc + 1'b1;
        end
        if (aluLoad)
        begin
            next_state.aluHold = aluResult;
        end
        if (statusLoad)
        begin
            next_state.status = statusIn;
        end
        if (acc)
        begin
            next_state.rdata = readVal;
        end
        if (apbRd)
        begin
            next_state.prdata = 32'h0000_0000;
            if (apbHit)
            begin
                next_state.prdata = {24'h00_0000, readVal};
            end
            else if (paddr == bdma_pkg::APB_PC_REG)
            begin
                next_state.prdata = {{(32 - PC_W){1'b0}}, state.pc};
            end
            else if (paddr == bdma_pkg::APB_STAT_REG)
            begin
                next_state.prdata = {23'h00_0000, state.dummy, state.status};
            end
        end
        if (wr && !(acc && !coreBitOp && coreBitOp))
        begin
            if (effAddr[8])
            begin
                if (effAddr[7:0] == bdma_pkg::EEC_ADDR)
                begin
                    next_state.eec = wdata & bdma_pkg::EEC_WMASK;
                end
            end
            else if (!effAddr[7])
            begin
                case (effAddr[7:0])
                    bdma_pkg::SFR_PTR_ZERO:
                        next_state.pointerZero = (state.pointerZero & ~wmask) | (wdata & wmask);
                    bdma_pkg::SFR_PTR_ONE:
                        next_state.pointerOne = (state.pointerOne & ~wmask) | (wdata & wmask);
                    bdma_pkg::SFR_BANK_SELECT:
                        next_state.bankSelect = ((state.bankSelect & ~wmask) | (wdata & wmask)) & 8'h01;
                    bdma_pkg::SFR_ALU_HOLD:
                        next_state.aluHold = (state.aluHold & ~wmask) | (wdata & wmask);
                    bdma_pkg::SFR_STATUS:
                        // upper flags stay read-only
                        next_state.status = (state.status & ~(wmask & bdma_pkg::STATUS_WMASK))
                                          | (wdata & wmask & bdma_pkg::STATUS_WMASK);
                    bdma_pkg::SFR_PC_LOW:
                    begin
                        // in-page jump with one dummy cycle
                        next_state.pc    = {state.pc[PC_W-1:8], (state.pc[7:0] & ~wmask) | (wdata & wmask)};
                        next_state.dummy = 1'b1;
                    end
                    default:
                        next_state.status = next_state.status;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state <= '0;
            if (wdtPowerDownReset)
            begin
                state.bankSelect <= state.bankSelect;
            end
            else
            begin
                state.bankSelect <= bdma_pkg::BANK_SELECT_RST;
            end
        end
        else
        begin
            state <= next_state;
        end
    end

    assign coreRdata      = state.rdata;
    assign aluHolder      = state.aluHold;
    assign statusOut      = state.status;
    assign programCounter = state.pc;
    assign dummyCycle     = state.dummy;
    assign eepromControl  = state.eec;
    assign prdata         = state.prdata;
endmodule
`default_nettype wire

/* File: logic/bdma_pkg.sv */
// bdma_pkg: constants for the banked data memory and its addressing.
// assumes nothing; used by bdma_top, bdma_props and tb through scoped names.
`default_nettype none
package bdma_pkg;
    localparam int          DATA_W          = 8;
    localparam int          ADDR_W          = 8;
    localparam int          PC_W            = 11;
    // special-function locations in bank 0, eeprom control in bank 1
    localparam logic [7:0]  SFR_PORT_ZERO   = 8'h00;
    localparam logic [7:0]  SFR_PTR_ZERO    = 8'h01;
    localparam logic [7:0]  SFR_PORT_ONE    = 8'h02;
    localparam logic [7:0]  SFR_PTR_ONE     = 8'h03;
    localparam logic [7:0]  SFR_BANK_SELECT = 8'h04;
    localparam logic [7:0]  SFR_ALU_HOLD    = 8'h05;
    localparam logic [7:0]  SFR_PC_LOW      = 8'h06;
    localparam logic [7:0]  SFR_STATUS      = 8'h0a;
    localparam logic [7:0]  GP_BASE         = 8'h80;
    localparam logic [7:0]  EEC_ADDR        = 8'h40;
    localparam logic [7:0]  BANK_SELECT_RST = 8'h00;
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;
    localparam logic [7:0]  STATUS_WMASK    = 8'h0f;
    localparam logic [7:0]  EEC_WMASK       = 8'h0f;
    localparam int          BANK_BIT        = 0;
    // apb register window for software
    localparam logic [11:0] APB_DATA_BASE   = 12'h000;
    localparam logic [11:0] APB_BANK1_BASE  = 12'h400;
    localparam logic [11:0] APB_PC_REG      = 12'h800;
    localparam logic [11:0] APB_STAT_REG    = 12'h804;
endpackage
`default_nettype wire

/* File: logic/bdma_gp_ram.sv */
// bdma_gp_ram: general-purpose byte ram with per-bit write mask.
// assumes one synchronous write port and an asynchronous read.
`timescale 1ns/10ps
`default_nettype none
module bdma_gp_ram #(
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic          sys_clk,
    input  wire logic [AW-1:0] addr,
    input  wire logic          we,
    input  wire logic [7:0]    wmask,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];

    assign rdata = mem[addr];

    // masked write leaves other bits untouched
    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
        end
    end
endmodule
`default_nettype wire

/* File: logic/bdma_apb_slave.sv */
// bdma_apb_slave: apb handshake, turns transfers into one-cycle strobes.
// assumes apb3 master on sys_clk; answers one cycle after penable.
`timescale 1ns/10ps
`default_nettype none
module bdma_apb_slave (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    output logic             pready,
    output logic             rdStrobe,
    output logic             wrStrobe
);
    typedef struct packed {
        logic done;
    } bdma_apb_t;
    bdma_apb_t state;
    bdma_apb_t next_state;

    always_comb
    begin
        next_state = state;
        next_state.done = psel && penable && !state.done;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign pready   = state.done;
    assign rdStrobe = psel && penable && !state.done && !pwrite;
    assign wrStrobe = psel && penable && !state.done && pwrite;
endmodule
`default_nettype wire

/* File: verif/bdma_props.sv */
// bdma_props: port checks for bdma_top.
// assumes binding into bdma_top; reset synchronous, active high.
`timescale 1ns/10ps
`default_nettype none
module bdma_props #(
    parameter int PC_W = 11
) (
    input wire logic            sys_clk,
    input wire logic            reset,
    input wire logic [7:0]      coreAddr,
    input wire logic            coreRead,
    input wire logic            coreWrite,
    input wire logic [7:0]      coreWdata,
    input wire logic [7:0]      coreRdata,
    input wire logic            aluLoad,
    input wire logic [7:0]      aluResult,
    input wire logic [7:0]      aluHolder,
    input wire logic            statusLoad,
    input wire logic [7:0]      statusOut,
    input wire logic [PC_W-1:0] programCounter,
    input wire logic            dummyCycle,
    input wire logic [7:0]      eepromControl
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    pcl_jump_a: assert property (
        coreWrite && coreAddr == bdma_pkg::SFR_PC_LOW |=> dummyCycle && programCounter[7:0] == $past(coreWdata))
        else $error("pc low write did not jump");
    dummy_single_a: assert property (
        dummyCycle |=> !dummyCycle) else $error("dummy cycle longer than one");
    page_kept_a: assert property (
        dummyCycle |-> programCounter[PC_W-1:8] == $past(programCounter[PC_W-1:8]))
        else $error("pc page changed on jump");
    alu_load_a: assert property (
        aluLoad |=> aluHolder == $past(aluResult)) else $error("alu result not held");
    eec_upper_a: assert property (
        eepromControl[7:4] == 4'h0) else $error("eeprom control upper bits set");
    status_ro_a: assert property (
        coreWrite && coreAddr == bdma_pkg::SFR_STATUS && !statusLoad |=> $stable(statusOut[5:4]))
        else $error("read-only status bits written");
    bank_read_a: assert property (
        coreRead && coreAddr == bdma_pkg::SFR_BANK_SELECT |=> coreRdata[7:1] == 7'h00)
        else $error("bank select upper bits not zero");
    unused_read_a: assert property (
        coreRead && coreAddr == 8'h7e |=> coreRdata == 8'h00) else $error("unused location not zero");
endmodule
`default_nettype wire

/* File: verif/bdma_core_model.sv */
// bdma_core_model: execution unit driving the data memory port.
// assumes sys_clk from the bench; one access per task call.
`timescale 1ns/10ps
`default_nettype none
module bdma_core_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] coreRdata,
    output logic      [7:0] coreAddr,
    output logic            coreRead,
    output logic            coreWrite,
    output logic            coreBitOp,
    output logic            coreBitSet,
    output logic      [2:0] coreBitSel,
    output logic      [7:0] coreWdata,
    output logic            aluLoad,
    output logic      [7:0] aluResult
);
    initial
    begin
        {coreAddr, coreRead, coreWrite, coreBitOp, coreBitSet, coreBitSel, coreWdata} = '0;
        {aluLoad, aluResult} = '0;
    end
    // op 0 read, 1 write, 2 bit clear, 3 bit set
    task automatic acc(input int op, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        coreAddr <= a;
        coreRead <= (op == 0);
        coreWrite <= (op == 1);
        coreBitOp <= (op >= 2);
        coreBitSet <= (op == 3);
        coreBitSel <= d[2:0];
        coreWdata <= d;
        @(posedge sys_clk);
        {coreRead, coreWrite, coreBitOp} <= 3'h0;
        coreAddr <= ~a;
        coreWdata <= ~d;
        #1 q = coreRdata;
    endtask
    // results reach memory only through the holder
    task automatic alu(input logic [7:0] v);
        @(posedge sys_clk);
        aluLoad <= 1'b1;
        aluResult <= v;
        @(posedge sys_clk);
        aluLoad <= 1'b0;
        aluResult <= ~v;
        @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// tb: bench for bdma_top with core model and apb master.
// assumes 100 MHz sys_clk and a 20-cycle reset at start.
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int    PC_W = bdma_pkg::PC_W;
    logic             sys_clk = 1'b0;
    logic             reset = 1'b1;
    logic             wdtPowerDownReset = 1'b0;
    logic [7:0]       coreAddr, coreWdata, coreRdata, aluResult, aluHolder, statusOut, eepromControl;
    logic             coreRead, coreWrite, coreBitOp, coreBitSet, aluLoad, dummyCycle;
    logic [2:0]       coreBitSel;
    logic [PC_W-1:0]  programCounter;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0, prdata, q;
    int               failCount = 0, checksDone = 0;
    always #5 sys_clk = ~sys_clk;
    bdma_core_model core_u (.sys_clk(sys_clk), .coreRdata(coreRdata), .coreAddr(coreAddr),
        .coreRead(coreRead), .coreWrite(coreWrite), .coreBitOp(coreBitOp), .coreBitSet(coreBitSet),
        .coreBitSel(coreBitSel), .coreWdata(coreWdata), .aluLoad(aluLoad), .aluResult(aluResult));
    bdma_top #(.PC_W(PC_W)) dut_u (.sys_clk(sys_clk), .reset(reset), .wdtPowerDownReset(wdtPowerDownReset),
        .coreAddr(coreAddr), .coreRead(coreRead), .coreWrite(coreWrite), .coreBitOp(coreBitOp),
        .coreBitSet(coreBitSet), .coreBitSel(coreBitSel), .coreWdata(coreWdata), .coreRdata(coreRdata),
        .aluLoad(aluLoad), .aluResult(aluResult), .aluHolder(aluHolder), .statusLoad(1'b0),
        .statusIn(8'h00), .statusOut(statusOut), .pcAdvance(1'b0), .programCounter(programCounter),
        .dummyCycle(dummyCycle), .eepromControl(eepromControl), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            failCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cw(input int o, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        core_u.acc(o, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        core_u.acc(0, a, 8'h00, r);
        chk({24'h0, r}, {24'h0, e});
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            failCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'b1);
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
    task automatic closeOut();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #100000;
        failCount++;
        closeOut();
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        rd(bdma_pkg::SFR_BANK_SELECT, 8'h00);
        chk(eepromControl, 32'h0);
        cw(1, 8'h80, 8'h3c);
        cw(1, 8'hff, 8'hc3);
        rd(8'hff, 8'hc3);
        cw(3, 8'h80, 8'h00);
        cw(2, 8'h80, 8'h05);
        rd(8'h80, 8'h1d);
        cw(1, 8'h7e, 8'h55);
        rd(8'h7e, 8'h00);
        cw(1, bdma_pkg::SFR_STATUS, 8'hff);
        rd(bdma_pkg::SFR_STATUS, 8'h0f);
        chk(statusOut, 32'h0f);
        $display("test direct done");
        cw(1, 8'h01, 8'h85);
        rd(8'h01, 8'h85);
        cw(1, 8'h00, 8'ha5);
        rd(8'h85, 8'ha5);
        cw(1, 8'h01, 8'h00);
        rd(8'h00, 8'h00);
        rd(8'h02, 8'h00);
        cw(1, 8'h04, 8'hff);
        rd(8'h04, 8'h01);
        cw(1, 8'h03, 8'h40);
        cw(1, 8'h02, 8'hff);
        chk(eepromControl, 32'h0f);
        rd(8'h02, 8'h0f);
        rd(8'h40, 8'h00);
        cw(1, 8'h01, 8'h40);
        rd(8'h00, 8'h00);
        cw(1, 8'h03, 8'h85);
        rd(8'h02, 8'h00);
        cw(1, 8'h02, 8'h11);
        cw(1, 8'h04, 8'h00);
        rd(8'h02, 8'ha5);
        $display("test indirect done");
        core_u.alu(8'h96);
        chk(aluHolder, 32'h96);
        rd(bdma_pkg::SFR_ALU_HOLD, 8'h96);
        cw(1, bdma_pkg::SFR_PC_LOW, 8'h34);
        chk(dummyCycle, 32'h1);
        chk(programCounter, 32'h34);
        $display("test alu pc done");
        cw(1, 8'h04, 8'h01);
        @(posedge sys_clk);
        reset <= 1'b1;
        wdtPowerDownReset <= 1'b1;
        @(posedge sys_clk);
        {reset, wdtPowerDownReset} <= 2'b00;
        rd(8'h04, 8'h01);
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        rd(8'h04, 8'h00);
        $display("test reset keep done");
        apb(1'b1, 12'h240, 32'h5a, q);
        rd(8'h90, 8'h5a);
        apb(1'b0, 12'h240, 32'h0, q);
        chk(q, 32'h5a);
        apb(1'b1, 12'h500, 32'hff, q);
        chk(eepromControl, 32'h0f);
        apb(1'b0, 12'h504, 32'h0, q);
        chk(q, 32'h0);
        apb(1'b0, 12'hffc, 32'h0, q);
        chk(q, 32'h0);
        apb(1'b0, 12'h800, 32'h0, q);
        chk(q, 32'h0);
        apb(1'b0, 12'h804, 32'h0, q);
        chk(q, 32'h0);
        chk(pslverr, 32'h0);
        $display("test apb done");
        closeOut();
    end
endmodule
bind bdma_top bdma_props #(.PC_W(PC_W)) props_u (.sys_clk(sys_clk), .reset(reset), .coreAddr(coreAddr),
    .coreRead(coreRead), .coreWrite(coreWrite), .coreWdata(coreWdata), .coreRdata(coreRdata),
    .aluLoad(aluLoad), .aluResult(aluResult), .aluHolder(aluHolder), .statusLoad(statusLoad),
    .statusOut(statusOut), .programCounter(programCounter), .dummyCycle(dummyCycle),
    .eepromControl(eepromControl));
`default_nettype wire
